// file: hw/tkl_pkg.sv
// Package for the token latch host controller.
// Assumes a 200 MHz ref_clk and an asynchronous dual-port part outside.
package tkl_pkg;
   // Clock period in picoseconds.
   localparam int CLK_PERIOD_PS = 5000;
   // Least strobe time for one latch access, in nanoseconds.
   localparam int ACCESS_NS = 35;
   // Cycles per strobe phase, rounded up.
   localparam int ACCESS_CYC = (ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // Number of token latches on the part.
   localparam int NUM_TOKENS = 8;
   // Width of the latch index.
   localparam int IDX_W = 3;
   // Data bus width of the part.
   localparam int DATA_W = 16;
   // Value written to claim a token.
   localparam logic CLAIM_VAL = 1'h0;
   // Value written to release a token.
   localparam logic FREE_VAL = 1'h1;
   // Command codes from the user side.
   typedef enum logic [1:0] {TKL_CMD_CLAIM, TKL_CMD_RELEASE, TKL_CMD_POLL, TKL_CMD_INIT} tkl_cmd_t;
endpackage : tkl_pkg

// file: hw/tkl_pins_if.sv
// Interface carrying the strobe timer handshake between host modules.
// Assumes both ends run on ref_clk.
`timescale 1ns/1ps
interface tkl_pins_if;
   logic start;
   logic done;
   modport master (output start, input done);
   modport timer (input start, output done);
endinterface : tkl_pins_if

// file: hw/tkl_phase_timer.sv
// Phase timer: pulses done a fixed number of cycles after start.
// Assumes start is a one-cycle pulse on ref_clk.
`timescale 1ns/1ps
module tkl_phase_timer
   import tkl_pkg::*;
#(
   parameter int CYCLES = ACCESS_CYC
)
(
   input wire logic ref_clk,
   input wire logic rst_n,
   tkl_pins_if.timer tmr
);
   // Refuse a count that cannot fit.
   if (CYCLES < 1 || CYCLES > 255) begin : g_chk
      $error("Phase timer count out of range.");
   end
   // Remaining cycles.
   logic [7:0] cnt_reg;
   // Busy flag.
   logic run_reg;
   // Done pulse register.
   logic done_reg;
   assign tmr.done = done_reg;
   // Count down from start to done.
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_reg <= 8'h00;
         run_reg <= 1'b0;
         done_reg <= 1'b0;
      end
      else
      begin
         done_reg <= run_reg && cnt_reg == 8'h01;
         if (tmr.start)
         begin
            cnt_reg <= 8'(CYCLES);
            run_reg <= 1'b1;
         end
         else if (run_reg)
         begin
            cnt_reg <= cnt_reg - 8'h01;
            run_reg <= cnt_reg != 8'h01;
         end
      end
   end
endmodule : tkl_phase_timer

// file: hw/tkl_host.sv
// Host controller that claims, releases and polls token latches of a
// dual-port memory through its flag-space pins. Assumes one port of the
// part is wired to the pin outputs and the data bus is resolved outside.
`timescale 1ns/1ps
// Summary of operation
// - Write zero claims, write one releases.
// - Access only with flag_space_select low.
// - Claim by write zero, then read back.
// - After failure, poll or withdraw with one.
// - Lift select or enable between polls.
// - Write one to all eight at start-up; here only on a TKL_CMD_INIT command, not by itself after reset.
// - Keep array select high during flag access.
module tkl_host
   import tkl_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic cmdValid,
   input wire tkl_cmd_t cmdCode,
   input wire logic [IDX_W-1:0] cmdIndex,
   output logic cmdReady,
   output logic rspValid,
   output logic rspGranted,
   output logic [NUM_TOKENS-1:0] heldMask,
   output logic flagSpaceSelect_n,
   output logic arraySelect_n,
   output logic outDriveEnable_n,
   output logic writeStrobe_n,
   output logic [IDX_W-1:0] flagIndex,
   output logic [DATA_W-1:0] dataOut,
   output logic dataOutEnable_n,
   input wire logic [DATA_W-1:0] dataIn
);
   // Host sequencer states.
   typedef enum logic [2:0] {S_IDLE, S_WR, S_GAP, S_RD, S_DONE} tkl_state_t;
   tkl_state_t state_reg;
   tkl_state_t state_next;
   // Latched command.
   tkl_cmd_t cmd_reg;
   // Init walk counter across all latches.
   logic [IDX_W-1:0] idx_reg;
   // Two-stage synchroniser on the data bus bit zero and its spread copy.
   logic [1:0] dSync1_reg;
   logic [1:0] dSync2_reg;
   // Phase timer link.
   tkl_pins_if tmr ();
   tkl_phase_timer #(.CYCLES(ACCESS_CYC)) u_timer (.ref_clk(ref_clk), .rst_n(rst_n), .tmr(tmr));
   // Decoded conditions.
   wire phaseDone = tmr.done;
   // A command is taken on the edge where the sequencer idles and one is offered.
   wire startIdle = state_reg == S_IDLE && cmdValid;
   // Command held after this edge, so the written bit is right from the first strobe cycle.
   wire tkl_cmd_t cmdNext = startIdle ? cmdCode : cmd_reg;
   wire needRead = cmd_reg == TKL_CMD_CLAIM || cmd_reg == TKL_CMD_POLL;
   wire lastInit = cmd_reg != TKL_CMD_INIT || idx_reg == IDX_W'(NUM_TOKENS - 1);
   // The init walk moves on to the next latch when a gap ends.
   wire idxStep = state_reg == S_GAP && phaseDone && !needRead && !lastInit;
   // Latch index after this edge; the pins take it too, so it stands for a whole strobe.
   wire [IDX_W-1:0] idxNext = startIdle ? ((cmdCode == TKL_CMD_INIT) ? '0 : cmdIndex)
                                        : (idxStep ? idx_reg + 1'b1 : idx_reg);
   wire wrVal = (cmdNext == TKL_CMD_CLAIM) ? CLAIM_VAL : FREE_VAL;
   // Read flag is low only when every sampled bit is low.
   wire flagLow = dSync2_reg == 2'h0;
   wire startPhase = startIdle || (phaseDone && state_next != S_DONE && state_next != S_IDLE);
   assign tmr.start = startPhase;
   // Next state: write then read back; a poll goes straight to the read without a write.
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         S_IDLE: if (cmdValid) state_next = (cmdCode == TKL_CMD_POLL) ? S_RD : S_WR;
         S_WR: if (phaseDone) state_next = S_GAP;
         S_GAP: if (phaseDone) state_next = needRead ? S_RD : (lastInit ? S_DONE : S_WR);
         S_RD: if (phaseDone) state_next = S_DONE;
         S_DONE: state_next = S_IDLE;
         default: state_next = S_IDLE;
      endcase
   end
   // Sequencer registers.
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg <= S_IDLE;
         cmd_reg <= TKL_CMD_POLL;
         idx_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
         cmd_reg <= cmdNext;
         idx_reg <= idxNext;
      end
   end
   // Synchronise the part's asynchronous data pins.
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         dSync1_reg <= 2'h3;
         dSync2_reg <= 2'h3;
      end
      else
      begin
         dSync1_reg <= {dataIn[DATA_W-1], dataIn[0]};
         dSync2_reg <= dSync1_reg;
      end
   end
   // Pin drive: select low only in write and read phases; gap lifts it.
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         flagSpaceSelect_n <= 1'b1;
         arraySelect_n <= 1'b1;
         outDriveEnable_n <= 1'b1;
         writeStrobe_n <= 1'b1;
         flagIndex <= '0;
         dataOut <= '1;
         dataOutEnable_n <= 1'b1;
      end
      else
      begin
         arraySelect_n <= 1'b1;
         flagSpaceSelect_n <= !(state_next == S_WR || state_next == S_RD);
         writeStrobe_n <= state_next != S_WR;
         dataOutEnable_n <= state_next != S_WR;
         outDriveEnable_n <= state_next != S_RD;
         flagIndex <= idxNext;
         dataOut <= {{(DATA_W-1){1'b1}}, wrVal};
      end
   end
   // User answers and the table of held tokens.
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cmdReady <= 1'b0;
         rspValid <= 1'b0;
         rspGranted <= 1'b0;
         heldMask <= '0;
      end
      else
      begin
         cmdReady <= state_next == S_IDLE;
         rspValid <= state_reg == S_RD && phaseDone;
         if (state_reg == S_RD && phaseDone)
         begin
            rspGranted <= flagLow;
            heldMask[idx_reg] <= flagLow;
         end
         else if (state_reg == S_GAP && phaseDone && cmd_reg == TKL_CMD_RELEASE)
            heldMask[idx_reg] <= 1'b0;
         else if (state_reg == S_GAP && phaseDone && cmd_reg == TKL_CMD_INIT)
            heldMask <= '0;
      end
   end
   // A command offered while the sequencer is idle is taken on the next edge.
   property p_take_idle;
      @(posedge ref_clk) disable iff (!rst_n)
      (state_reg == S_IDLE && cmdValid) |=> (state_reg == S_WR || state_reg == S_RD);
   endproperty
   a_take_idle: assert property (p_take_idle) else $error("Command not taken.");
   // Array select never drops.
   property p_array_high;
      @(posedge ref_clk) disable iff (!rst_n) arraySelect_n;
   endproperty
   a_array_high: assert property (p_array_high) else $error("Array selected.");
   // A write strobe only with flag select.
   property p_wr_sel;
      @(posedge ref_clk) disable iff (!rst_n) !writeStrobe_n |-> !flagSpaceSelect_n;
   endproperty
   a_wr_sel: assert property (p_wr_sel) else $error("Write without select.");
   // Never strobe write and output enable together.
   property p_no_both;
      @(posedge ref_clk) disable iff (!rst_n) !(!writeStrobe_n && !outDriveEnable_n);
   endproperty
   a_no_both: assert property (p_no_both) else $error("Read and write overlap.");
   // Claim writes zero on bit zero.
   property p_claim_zero;
      @(posedge ref_clk) disable iff (!rst_n)
      (!writeStrobe_n && cmd_reg == TKL_CMD_CLAIM) |-> dataOut[0] == CLAIM_VAL;
   endproperty
   a_claim_zero: assert property (p_claim_zero) else $error("Claim not zero.");
   // Release writes one.
   property p_rel_one;
      @(posedge ref_clk) disable iff (!rst_n)
      (!writeStrobe_n && cmd_reg != TKL_CMD_CLAIM) |-> dataOut[0] == FREE_VAL;
   endproperty
   a_rel_one: assert property (p_rel_one) else $error("Release not one.");
   // Select lifts between a write and the read back.
   sequence s_wr_end;
      !writeStrobe_n ##1 writeStrobe_n;
   endsequence
   property p_gap;
      @(posedge ref_clk) disable iff (!rst_n) s_wr_end |-> flagSpaceSelect_n;
   endproperty
   a_gap: assert property (p_gap) else $error("No gap after write.");
   // Each answer follows its read within a bounded time.
   property p_rsp;
      @(posedge ref_clk) disable iff (!rst_n)
      $fell(outDriveEnable_n) |-> ##[1:20] rspValid;
   endproperty
   a_rsp: assert property (p_rsp) else $error("Answer missing.");
   // The latch index and the written bit stand still for the whole write strobe.
   property p_wr_hold;
      @(posedge ref_clk) disable iff (!rst_n)
      (!writeStrobe_n && $past(!writeStrobe_n)) |-> $stable(flagIndex) && $stable(dataOut);
   endproperty
   a_wr_hold: assert property (p_wr_hold) else $error("Write index or data moved.");
endmodule : tkl_host

// file: verification/tkl_dev_model.sv
// Behavioural dual-port part with eight token latches.
// Side A faces the host pins; side B is driven by the bench.
`timescale 1ns/1ps
module tkl_dev_model
   import tkl_pkg::*;
(
   input logic aSel_n,
   input logic aOe_n,
   input logic aWe_n,
   input logic [IDX_W-1:0] aIdx,
   input logic [DATA_W-1:0] aD,
   output logic [DATA_W-1:0] aQ,
   input logic bSel_n,
   input logic bOe_n,
   input logic bWe_n,
   input logic [IDX_W-1:0] bIdx,
   input logic bD,
   output logic bQ
);
   // Request latches, low means requesting; no array beside them.
   logic [NUM_TOKENS-1:0] rqA = 8'h00;
   logic [NUM_TOKENS-1:0] rqB = 8'hFF;
   // Grant per token: 0 free, 1 side A, 2 side B.
   logic [1:0] own [NUM_TOKENS];
   logic [IDX_W-1:0] wi;
   logic wd;
   wire aWr = !aSel_n && !aWe_n;
   initial foreach (own[k]) own[k] = 2'h1;
   initial aQ = 16'h0000;
   // Frees or passes one token after a write; the first writer wins.
   function automatic void settle(input int i);
      if (own[i] == 2'h1 && rqA[i]) own[i] = rqB[i] ? 2'h0 : 2'h2;
      if (own[i] == 2'h2 && rqB[i]) own[i] = rqA[i] ? 2'h0 : 2'h1;
      if (own[i] == 2'h0) own[i] = !rqA[i] ? 2'h1 : (!rqB[i] ? 2'h2 : 2'h0);
   endfunction : settle
   // Takes index and bit zero while the host write is active and holds them after it ends.
   always @* if (aWr) {wi, wd} = {aIdx, aD[0]};
   // Commits the host write when it ends.
   always @(negedge aWr)
   begin
      rqA[wi] = wd;
      settle(wi);
   end
   // Commits a side B write when its strobe ends.
   always @(posedge bWe_n)
   begin
      if (!bSel_n)
      begin
         rqB[bIdx] = bD;
         settle(bIdx);
      end
   end
   // Read value is latched on select and enable, spread over all bits.
   // The short delay lets an index launched on the same edge settle first.
   always @(negedge (aSel_n | aOe_n)) #1 aQ = {DATA_W{own[aIdx] != 2'h1}};
   // A released bus shows the inverse, never the last value.
   always @(posedge (aSel_n | aOe_n)) aQ = ~aQ;
   always @(negedge (bSel_n | bOe_n)) bQ = own[bIdx] != 2'h2;
endmodule : tkl_dev_model

// file: verification/dual_port_token_latches_bench.sv
// Self-checking bench for the token latch host controller.
// Side B of the part model is driven here in the other host's place.
`timescale 1ns/1ps
module dual_port_token_latches_bench;
   import tkl_pkg::*;
   logic ref_clk = 1'h0;
   logic rst_n = 1'h0;
   logic cmdValid = 1'h0;
   tkl_cmd_t cmdCode = TKL_CMD_INIT;
   logic [IDX_W-1:0] cmdIndex = 3'h0;
   logic cmdReady, rspValid, rspGranted, fs_n, as_n, oe_n, we_n, de_n, bQ;
   logic [NUM_TOKENS-1:0] heldMask;
   logic [IDX_W-1:0] flagIndex;
   logic [DATA_W-1:0] dataOut, dataIn;
   logic bSel_n = 1'h1, bOe_n = 1'h1, bWe_n = 1'h1, bD = 1'h1, prevWs = 1'h1;
   logic [IDX_W-1:0] bIdx = 3'h0;
   int miscompares = 0, n_tests = 0;
   logic [3:0] wrLog [$];
   tkl_host dut (.ref_clk(ref_clk), .rst_n(rst_n), .cmdValid(cmdValid), .cmdCode(cmdCode),
      .cmdIndex(cmdIndex), .cmdReady(cmdReady), .rspValid(rspValid), .rspGranted(rspGranted),
      .heldMask(heldMask), .flagSpaceSelect_n(fs_n), .arraySelect_n(as_n),
      .outDriveEnable_n(oe_n), .writeStrobe_n(we_n), .flagIndex(flagIndex),
      .dataOut(dataOut), .dataOutEnable_n(de_n), .dataIn(dataIn));
   tkl_dev_model dev (.aSel_n(fs_n), .aOe_n(oe_n), .aWe_n(we_n), .aIdx(flagIndex),
      .aD(dataOut), .aQ(dataIn), .bSel_n(bSel_n), .bOe_n(bOe_n), .bWe_n(bWe_n),
      .bIdx(bIdx), .bD(bD), .bQ(bQ));
   initial forever #2.5 ref_clk = ~ref_clk;
   // Prints the counts and the verdict, then stops.
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
         miscompares++;
      end
   endtask : chk
   // Logs each host write at mid-cycle, where pins are settled, and checks the pin roles.
   always @(negedge ref_clk)
   begin
      if (!we_n && prevWs) wrLog.push_back({flagIndex, dataOut[0]});
      if (fs_n === 1'h0) chk(as_n, 1'h1);
      if (we_n === 1'h0) chk(de_n, 1'h0);
      if (oe_n === 1'h0) chk({fs_n, de_n}, 2'h1);
      prevWs <= we_n;
   end
   // Issues one command and judges the granted answer of a claim or poll.
   task automatic cmd(input tkl_cmd_t c, input logic [2:0] i, input logic e);
      logic g;
      int k;
      g = 1'hx;
      @(posedge ref_clk) #1;
      for (k = 0; k < 400 && cmdReady !== 1'h1; k++) @(posedge ref_clk) #1;
      if (cmdReady !== 1'h1)
      begin
         miscompares++;
         end_of_test();
      end
      cmdCode = c;
      cmdIndex = i;
      cmdValid = 1'h1;
      @(posedge ref_clk) #1 cmdValid = 1'h0;
      for (k = 0; k < 400; k++)
      begin
         @(posedge ref_clk) #1;
         if (rspValid === 1'h1) g = rspGranted;
         if (cmdReady === 1'h1) break;
      end
      if (k == 400)
      begin
         miscompares++;
         end_of_test();
      end
      if (c == TKL_CMD_CLAIM || c == TKL_CMD_POLL) chk(g, e);
   endtask : cmd
   // One side B access; a read leaves the latched flag in bQ.
   task automatic bAcc(input logic [2:0] i, input logic w, input logic v);
      bIdx = i;
      bD = v;
      #2 bSel_n = 1'h0;
      bWe_n = !w;
      bOe_n = w;
      #40 bWe_n = 1'h1;
      bOe_n = 1'h1;
      #2 bSel_n = 1'h1;
   endtask : bAcc
   task automatic bRd(input logic [2:0] i, input logic e);
      bAcc(i, 1'h0, 1'h0);
      chk(bQ, e);
   endtask : bRd
   // Frees every token from both sides and checks the write order.
   task automatic t_init();
      wrLog.delete();
      cmd(TKL_CMD_INIT, 3'h0, 1'h0);
      for (int i = 0; i < NUM_TOKENS; i++) bAcc(i[2:0], 1'h1, 1'h1);
      chk(wrLog.size(), 16'h0008);
      foreach (wrLog[i]) chk(wrLog[i], {i[2:0], 1'h1});
      chk(heldMask, 8'h00);
   endtask : t_init
   // Claim, contention, hand-over, withdrawal and release of one token.
   task automatic t_claim();
      wrLog.delete();
      cmd(TKL_CMD_CLAIM, 3'h3, 1'h1);
      chk(wrLog[0], {3'h3, 1'h0});
      chk(heldMask, 8'h08);
      bRd(3'h3, 1'h1);
      bAcc(3'h3, 1'h1, 1'h0);
      bRd(3'h3, 1'h1);
      cmd(TKL_CMD_POLL, 3'h3, 1'h1);
      cmd(TKL_CMD_RELEASE, 3'h3, 1'h0);
      chk(heldMask, 8'h00);
      bRd(3'h3, 1'h0);
      cmd(TKL_CMD_CLAIM, 3'h3, 1'h0);
      cmd(TKL_CMD_RELEASE, 3'h3, 1'h0);
      bAcc(3'h3, 1'h1, 1'h1);
      cmd(TKL_CMD_POLL, 3'h3, 1'h0);
      bAcc(3'h3, 1'h1, 1'h0);
      bRd(3'h3, 1'h0);
      bAcc(3'h3, 1'h1, 1'h1);
   endtask : t_claim
   // Neighbouring latches stay apart at the highest index.
   task automatic t_index();
      cmd(TKL_CMD_CLAIM, 3'h7, 1'h1);
      chk(heldMask, 8'h80);
      bAcc(3'h6, 1'h1, 1'h0);
      bRd(3'h6, 1'h0);
      cmd(TKL_CMD_POLL, 3'h6, 1'h0);
      cmd(TKL_CMD_RELEASE, 3'h7, 1'h0);
      bAcc(3'h6, 1'h1, 1'h1);
   endtask : t_index
   initial
   begin
      repeat (5) @(posedge ref_clk);
      #1 rst_n = 1'h1;
      t_init();
      t_claim();
      t_index();
      end_of_test();
   end
endmodule : dual_port_token_latches_bench
